// *** bnvr_dev_model.sv ***
/* Behavioural model of the memory device and its data bus.
 Assumes host pins change just after clk edges. */
`timescale 1ns/1ps
`default_nettype none
module bnvr_dev_model
   import bnvr_pkg::*;
(
   input wire logic clk,
   input wire bnvr_pkg::bnvr_pins_type pins,
   output logic [bnvr_pkg::DATA_WIDTH-1:0] bus
);
   logic [DATA_WIDTH-1:0] mem [WORDS];
   logic [ADDR_WIDTH-1:0] addr;
   logic wr = 1'b0;
   logic sel_q = 1'b1;
   logic [DATA_WIDTH-1:0] flt = 8'h5a;
   int n = 0;
   // A released bus toggles so that a late sample never looks like good data.
   wire logic drive = !pins.select_n && !sel_q && !pins.output_drive_n && !wr
      && pins.write_strobe_n
      && n >= ACCESS_CYCLES - 1;
   assign bus = !pins.data_oe_n ? pins.data_out : (drive ? mem[addr] : flt);
   always @(posedge clk) begin
      sel_q <= pins.select_n;
      flt <= ~flt;
      n <= n + 1;
      if (sel_q && !pins.select_n) begin
         addr <= pins.addr;
         wr <= !pins.write_strobe_n;
         n <= 1;
      end
      if (!sel_q && !pins.select_n && !pins.write_strobe_n) mem[addr] <= bus;
   end
endmodule // bnvr_dev_model
`default_nettype wire

// *** bnvr_host.sv ***
/*
 Host controller that drives the select, output drive and write strobe pins of a
 bytewide nonvolatile RAM and runs one read or write per request.
 Assumes the device pins are synchronous to clk and the data bus is resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1: Address stable at select falling edge.
// RULE2: Address held until hold time passes.
// RULE3: Output drive low only for reads.
// RULE4: Write strobe low stores data bus byte.
// RULE5: Pin states encode standby, read, write.
// RULE6: Fresh select fall for every access.
// RULE7: Same timing for reads and writes.
// RULE8: Select high starts device precharge.
// RULE9: Device finishes cycle after early deassert.
// RULE10: Read data sampled after access time.
// RULE11: Device hides data before access completes.
// RULE12: Strobe low before select: select-controlled write.
// RULE13: Strobe after select would start read.
// RULE14: Write ends at first rising edge.
// RULE15: No busy polling; back-to-back accesses allowed.
// RULE16: Select held high for precharge time.
// RULE17: Select low time stays bounded.
// RULE18: Array is 1024 rows of 64 bits.
// RULE19: Read data valid within access time.
// RULE20: Select low at least active time.
// RULE21: Request latched in state until precharge ends.
module bnvr_host
   import bnvr_pkg::*;
#(
   parameter int ACCESS_CYC = ACCESS_CYCLES,
   parameter int ACTIVE_CYC = ACTIVE_CYCLES,
   parameter int PRECHARGE_CYC = PRECHARGE_CYCLES,
   parameter int HOLD_CYC = HOLD_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic req_valid,
   output logic req_ready,
   input wire bnvr_pkg::bnvr_req_type req,
   output logic rsp_valid,
   output logic [bnvr_pkg::DATA_WIDTH-1:0] rsp_rdata,
   output bnvr_pkg::bnvr_pins_type pins,
   input wire logic [bnvr_pkg::DATA_WIDTH-1:0] data_in
);
   import bnvr_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SETUP = 4'b0010,
      ST_ACTIVE = 4'b0100,
      ST_PRECHARGE = 4'b1000
   } bnvr_state_type;

   bnvr_state_type state;
   bnvr_state_type next_state;
   bnvr_req_type held;
   logic [DATA_WIDTH-1:0] rdata;
   logic done_pulse;
   logic timer_load;
   logic timer_done;
   logic [COUNT_WIDTH-1:0] timer_value;
   logic take_req;
   logic active_end;
   logic [COUNT_WIDTH-1:0] active_len;
   logic in_idle;
   logic in_setup;
   logic in_active;
   logic in_precharge;
   logic precharge_end;
   logic held_read;
   logic capture_read;
   logic [DATA_WIDTH-1:0] next_rdata;
   bnvr_req_type next_held;

   logic next_select_n;
   logic next_output_drive_n;
   logic next_write_strobe_n;
   logic next_data_oe_n;
   logic [ADDR_WIDTH-1:0] next_addr;
   logic [DATA_WIDTH-1:0] next_data_out;
   bnvr_pins_type next_pins;

   localparam int ACT_LEN = (ACCESS_CYC > ACTIVE_CYC) ? ACCESS_CYC : ACTIVE_CYC;

   // Idle pin levels: select and both strobes high, bus released, address parked.
   localparam bnvr_pins_type PINS_RESET = '{
      select_n: 1'b1,
      output_drive_n: 1'b1,
      write_strobe_n: 1'b1,
      addr: '0,
      data_out: '0,
      data_oe_n: 1'b1
   };

   assign in_idle = (state == ST_IDLE);
   assign in_setup = (state == ST_SETUP);
   assign in_active = (state == ST_ACTIVE);
   assign in_precharge = (state == ST_PRECHARGE);
   assign held_read = !held.write;

   assign take_req = in_idle && req_valid;
   assign req_ready = in_idle;
   // Both reads and writes use the same active length, so cycle time is uniform.
   // Select is never held low past this length, so the low-time limit cannot be broken.
   assign active_len = COUNT_WIDTH'(ACT_LEN - 1); // RULE7 RULE19 RULE20 RULE17
   assign active_end = in_active && timer_done;
   assign precharge_end = in_precharge && timer_done;
   assign timer_load = in_setup || active_end;
   // One timer serves both phases; it is reloaded on the edge that starts each phase.
   assign timer_value = in_setup ? active_len : COUNT_WIDTH'(PRECHARGE_CYC - 1);

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (req_valid) begin
               next_state = ST_SETUP;
            end
         end
         // The setup cycle lets address and strobe settle before select falls.
         ST_SETUP: next_state = ST_ACTIVE; // RULE6
         ST_ACTIVE: begin
            if (timer_done) begin
               next_state = ST_PRECHARGE; // RULE8
            end
         end
         ST_PRECHARGE: begin
            // No device busy check: the next access starts once precharge has elapsed.
            if (timer_done) begin
               next_state = ST_IDLE; // RULE16 RULE15
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // The count width is fixed by the package; longer phases need a wider count.
   bnvr_timer #(
      .WIDTH(COUNT_WIDTH)
   ) u_timer (
      .clk(clk),
      .reset(reset),
      .load(timer_load),
      .value(timer_value),
      .done(timer_done)
   );

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         held <= '0;
      end else begin
         held <= next_held; // RULE21
      end
   end

   assign next_held = take_req ? req : held; // RULE2
   // Read data is taken on the edge that raises select, while the device still drives.
   assign capture_read = active_end && held_read; // RULE10
   assign next_rdata = capture_read ? data_in : rdata;

   always_ff @(posedge clk) begin
      if (reset) begin
         rdata <= '0;
      end else begin
         rdata <= next_rdata;
      end
   end

   // One pulse per access, writes included, since a write needs no completion poll.
   always_ff @(posedge clk) begin
      if (reset) begin
         done_pulse <= 1'b0;
      end else begin
         done_pulse <= active_end;
      end
   end

   // Address and write data stay on the pins until the next request replaces them.
   assign next_addr = take_req ? req.addr : pins.addr; // RULE1
   assign next_data_out = take_req ? req.wdata : pins.data_out;
   // Strobe drops before select so the device starts the cycle as a write.
   assign next_write_strobe_n = take_req ? !req.write // RULE12 RULE5 RULE4
      : (active_end ? 1'b1 : pins.write_strobe_n); // RULE14
   // The bus stays driven through precharge, so write data outlasts both rising strobes.
   assign next_data_oe_n = take_req ? !req.write
      : (precharge_end ? 1'b1 : pins.data_oe_n);
   assign next_select_n = in_setup ? 1'b0 // RULE1 RULE6
      : (active_end ? 1'b1 : pins.select_n); // RULE14 RULE9
   assign next_output_drive_n = in_setup ? held.write // RULE3 RULE11
      : (active_end ? 1'b1 : pins.output_drive_n);

   assign next_pins = '{
      select_n: next_select_n,
      output_drive_n: next_output_drive_n,
      write_strobe_n: next_write_strobe_n,
      addr: next_addr,
      data_out: next_data_out,
      data_oe_n: next_data_oe_n
   };

   always_ff @(posedge clk) begin
      if (reset) begin
         pins <= PINS_RESET;
      end else begin
         pins <= next_pins;
      end
   end

   assign rsp_valid = done_pulse;
   assign rsp_rdata = rdata;
endmodule // bnvr_host
`default_nettype wire

// *** bnvr_pkg.sv ***
/*
 Package for the host-side controller of a bytewide nonvolatile RAM port.
 Holds widths, timing figures and the cycle counts derived from a 100 MHz clock.
*/
package bnvr_pkg;
   localparam int ADDR_WIDTH = 13;
   localparam int DATA_WIDTH = 8;
   localparam int WORDS = 8192;
   localparam int ROWS = 1024;
   localparam int ROW_BITS = 64;
   localparam int ROW_BYTES = ROW_BITS / DATA_WIDTH;
   localparam int CLK_PERIOD_NS = 10;
   localparam int ACCESS_TIME_NS = 80;
   localparam int ACTIVE_TIME_NS = 80;
   localparam int PRECHARGE_TIME_NS = 65;
   localparam int ADDR_HOLD_NS = 10;
   localparam int ACCESS_CYCLES = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACTIVE_CYCLES = (ACTIVE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PRECHARGE_CYCLES = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYCLES = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int COUNT_WIDTH = 8;

   typedef struct packed {
      logic write;
      logic [ADDR_WIDTH-1:0] addr;
      logic [DATA_WIDTH-1:0] wdata;
   } bnvr_req_type;

   typedef struct packed {
      logic select_n;
      logic output_drive_n;
      logic write_strobe_n;
      logic [ADDR_WIDTH-1:0] addr;
      logic [DATA_WIDTH-1:0] data_out;
      logic data_oe_n;
   } bnvr_pins_type;
endpackage

// *** bnvr_props.sv ***
/* Checker on the host pin sequence.
 Assumes the default timing parameters of the host. */
`timescale 1ns/1ps
`default_nettype none
module bnvr_props
   import bnvr_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire bnvr_pkg::bnvr_req_type req,
   input wire logic rsp_valid,
   input wire logic [bnvr_pkg::DATA_WIDTH-1:0] rsp_rdata,
   input wire bnvr_pkg::bnvr_pins_type pins,
   input wire logic [bnvr_pkg::DATA_WIDTH-1:0] data_in
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_take; req_valid && req_ready; endsequence
   sequence s_fall; $fell(pins.select_n); endsequence
   a_sel_start: assert property (s_take |-> ##[2:3] s_fall)
      else $error("select did not fall");
   a_sel_low: assert property (s_fall |-> !pins.select_n[*8] ##1 pins.select_n)
      else $error("select low time wrong");
   a_precharge: assert property ($rose(pins.select_n) |-> pins.select_n[*7])
      else $error("precharge too short");
   a_rsp_time: assert property (s_take |-> ##10 rsp_valid)
      else $error("response late");
   a_addr_hold: assert property (!pins.select_n |-> $stable(pins.addr))
      else $error("address moved");
   a_oe_read: assert property (!pins.output_drive_n |-> pins.write_strobe_n && pins.data_oe_n)
      else $error("output drive in write");
   a_strobe_first: assert property ($fell(pins.write_strobe_n) |-> pins.select_n)
      else $error("strobe fell late");
   a_write_end: assert property ($rose(pins.select_n) |-> pins.write_strobe_n)
      else $error("strobe rose late");
endmodule // bnvr_props
bind bnvr_host bnvr_props u_props (.clk(clk), .reset(reset), .req_valid(req_valid),
   .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
   .pins(pins), .data_in(data_in));
`default_nettype wire

// *** bnvr_tb.sv ***
/* Self-checking bench of the host with the device model and a reference memory.
 Assumes the default timing parameters. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import bnvr_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic req_valid = 1'b0;
   bnvr_req_type req = '0;
   logic req_ready, rsp_valid;
   logic [DATA_WIDTH-1:0] rsp_rdata, data_in;
   bnvr_pins_type pins;
   int errors = 0;
   int tests_run = 0;
   logic [7:0] ref_mem [int];
   logic [12:0] a;
   always #5 clk = ~clk;
   bnvr_host uut (.clk(clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
      .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pins(pins), .data_in(data_in));
   bnvr_dev_model dev (.clk(clk), .pins(pins), .bus(data_in));
   task check(input logic [7:0] got, input logic [7:0] want);
      tests_run++;
      if (got !== want) begin
         errors++;
         $display("FAIL t=%0t got=%h want=%h", $time, got, want);
      end
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task op(input logic w, input logic [12:0] ad, input logic [7:0] d);
      int k;
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{write: w, addr: ad, wdata: d};
      k = 0;
      do begin @(negedge clk); k++; end while (req_ready !== 1'b1 && k < 100);
      @(posedge clk);
      req_valid <= 1'b0;
      if (w) ref_mem[ad] = d;
      k = 0;
      do begin @(negedge clk); k++; end while (rsp_valid !== 1'b1 && k < 100);
      check({7'h00, rsp_valid}, 8'h01);
      if (!w) check(rsp_rdata, ref_mem[ad]);
   endtask
   initial begin
      void'($urandom(32'h8373_34bc));
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      // The span wraps from the top of the array to the bottom, across rows.
      for (int i = 0; i < 10; i++) op(1'b1, 13'h1ffc + 13'(i), 8'($urandom));
      for (int i = 9; i >= 0; i--) op(1'b0, 13'h1ffc + 13'(i), 8'($urandom));
      $display("test wrap done");
      repeat (20) begin
         a = 13'($urandom);
         op(1'b1, a, 8'($urandom));
         op(1'b0, a, 8'h00);
         op(1'b0, 13'h1ffc, 8'h00);
      end
      $display("test random done");
      give_verdict;
   end
   initial begin
      #100000;
      errors++;
      give_verdict;
   end
endmodule // testbench
`default_nettype wire

// *** bnvr_timer.sv ***
/*
 Down counter used to time the phases of a memory cycle.
 Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module bnvr_timer #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic load,
   input wire logic [WIDTH-1:0] value,
   output logic done
);
   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;

   assign next_count = load ? value : (count != '0 ? count - WIDTH'(1) : count);
   // Done depends on the count alone; the load that it triggers must not feed back into it.
   assign done = (count == '0);

   always_ff @(posedge clk) begin
      if (reset) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end
endmodule // bnvr_timer
`default_nettype wire
